// ### rtl/qshz_drive_end.sv
`timescale 1ns/1ps
module qshz_drive_end
  import qshz_pkg::*;
#(
  parameter int HOLD_LIMIT = HOLD_LIMIT_CYC,
  parameter int CNT_PER_MM = 1,
  parameter int HOLD_W     = 30
)(
  input  logic               clk,
  input  logic               srst,
  qshz_link_if.drive         link,
  input  logic               serialMode,
  input  logic               holdFuncEn,
  input  logic [SEL_W-1:0]   holdSel,
  input  logic               pfFuncEn,
  input  logic [SEL_W-1:0]   pfSel,
  input  logic               carHeavyIn,
  input  logic               faultReset,
  input  logic signed [31:0] position,
  output logic               motorEnergise,
  output logic               encSupervise,
  output logic               altParamSet,
  output logic               carHeavier,
  output logic               travelDown,
  output logic               faultActive,
  output logic [9:0]         faultCode,
  output logic [1:0]         speedSel
);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_LIMIT - 1);
  localparam logic [32:0]       CREEP_CNT = 33'(CREEP_LIMIT_MM * CNT_PER_MM);

  qshz_dev_state_t    state;
  qshz_dev_state_t    next_state;
  logic [HOLD_W-1:0]  holdCnt;
  logic [HOLD_W-1:0]  next_holdCnt;
  logic signed [31:0] posStart;
  logic signed [31:0] next_posStart;
  logic [9:0]         next_faultCode;
  logic               next_carHeavier;
  logic               next_travelDown;
  logic [1:0]         next_speedSel;
  logic               driveReady;
  logic               brakeRelease;
  logic               next_driveReady;
  logic               next_brakeRelease;
  logic               next_motorEnergise;
  logic               next_encSupervise;
  logic               next_altParamSet;

  logic               holdReq;
  logic               enReq;
  logic               dirOk;
  logic               downReq;
  logic               speedReq;
  logic [1:0]         speedCode;
  logic signed [32:0] drift;
  logic [32:0]        driftAbs;
  logic               crept;

  // request decoding, discrete or serial
  always_comb
  begin
    if (serialMode)
    begin
      holdReq  = link.speedByte[ZERO_RPM_CMD_BIT];
      enReq    = link.cmdByte[CMD_ENABLE_BIT] & link.cmdByte[TRAVEL_COMMAND_BIT]
                 & link.cmdByte[OFF_SWITCH_BIT];
      dirOk    = 1'b1;
      downReq  = link.cmdByte[DIRECTION_CMD_BIT];
      speedReq = link.cmdByte[TRAVEL_SPEED_CMD_BIT]
                 & (link.speedByte[INTERMEDIATE_SPEED_CMD_BIT]
                 | link.speedByte[FAST_SPEED_CMD_BIT]);
      if (link.speedByte[FAST_SPEED_CMD_BIT])
        speedCode = SPD_FULL;
      else
        speedCode = SPD_INTER;
    end
    else
    begin
      holdReq  = holdFuncEn & link.progIn[holdSel];
      enReq    = link.driveEnableIn;
      dirOk    = link.travelDirectionIn ^ link.directionDownIn;
      downReq  = link.directionDownIn;
      speedReq = link.positioningSpeedIn | link.intermediateSpeedIn
                 | link.fullTravelSpeedIn;
      if (link.fullTravelSpeedIn)
        speedCode = SPD_FULL;
      else if (link.intermediateSpeedIn)
        speedCode = SPD_INTER;
      else
        speedCode = SPD_POS;
    end
  end

  // displacement since hold began, either direction
  always_comb
  begin
    drift = 33'(position) - 33'(posStart);
    if (drift[32])
      driftAbs = 33'(-drift);
    else
      driftAbs = 33'(drift);
    crept = driftAbs > CREEP_CNT;
  end

  always_comb
  begin
    next_state      = state;
    next_holdCnt    = '0;
    next_posStart   = posStart;
    next_faultCode  = faultCode;
    next_carHeavier = carHeavier;
    next_travelDown = travelDown;
    next_speedSel   = speedSel;
    case (state)
      D_IDLE:
      begin
        next_speedSel = SPD_ZERO;
        if (enReq && dirOk && (holdReq || speedReq))
        begin
          next_state      = D_READY;
          next_carHeavier = carHeavyIn;
          next_travelDown = downReq;
        end
      end
      D_READY:
      begin
        if (!enReq)
          next_state = D_IDLE;
        else if (link.contactorClosed)
          next_state = D_ENERG;
      end
      D_ENERG:
      begin
        next_posStart = position;
        if (!enReq)
          next_state = D_IDLE;
        else if (holdReq)
          next_state = D_HOLD;
        else
        begin
          next_state    = D_TRAVEL;
          next_speedSel = speedCode;
        end
      end
      D_HOLD:
      begin
        next_holdCnt  = holdCnt + 1'b1;
        next_speedSel = SPD_ZERO;
        if (crept)
        begin
          next_state     = D_FAULT;
          next_faultCode = FAULT_CREEP;
        end
        else if (holdCnt == HOLD_LAST)
        begin
          next_state     = D_FAULT;
          next_faultCode = FAULT_HOLD_TIME;
        end
        else if (!enReq)
          next_state = D_IDLE;
        else if (!holdReq && speedReq)
        begin
          next_state    = D_TRAVEL;
          next_speedSel = speedCode;
        end
      end
      D_TRAVEL:
      begin
        if (holdReq)
        begin
          next_state     = D_FAULT;
          next_faultCode = FAULT_HOLD_TRIP;
        end
        else if (!enReq)
          next_state = D_IDLE;
        else if (speedReq)
          next_speedSel = speedCode;
      end
      D_FAULT:
      begin
        next_speedSel = SPD_ZERO;
        // stays latched whatever the controller does
        if (faultReset)
        begin
          next_state     = D_IDLE;
          next_faultCode = FAULT_NONE;
        end
      end
      default:
        next_state = D_IDLE;
    endcase
  end

  // outputs other than altParamSet follow the next state so they line up with it
  always_comb
  begin
    next_driveReady    = (next_state == D_READY) || (next_state == D_ENERG)
                         || (next_state == D_HOLD) || (next_state == D_TRAVEL);
    next_motorEnergise = (next_state == D_ENERG) || (next_state == D_HOLD)
                         || (next_state == D_TRAVEL);
    next_brakeRelease  = (next_state == D_HOLD) || (next_state == D_TRAVEL);
    next_encSupervise  = next_state == D_TRAVEL;
    next_altParamSet   = pfFuncEn & link.progIn[pfSel];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state         <= D_IDLE;
      holdCnt       <= '0;
      posStart      <= '0;
      faultCode     <= FAULT_NONE;
      carHeavier    <= 1'b0;
      travelDown    <= 1'b0;
      speedSel      <= SPD_ZERO;
      driveReady    <= 1'b0;
      brakeRelease  <= 1'b0;
      motorEnergise <= 1'b0;
      encSupervise  <= 1'b0;
      altParamSet   <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      holdCnt       <= next_holdCnt;
      posStart      <= next_posStart;
      faultCode     <= next_faultCode;
      carHeavier    <= next_carHeavier;
      travelDown    <= next_travelDown;
      speedSel      <= next_speedSel;
      driveReady    <= next_driveReady;
      brakeRelease  <= next_brakeRelease;
      motorEnergise <= next_motorEnergise;
      encSupervise  <= next_encSupervise;
      altParamSet   <= next_altParamSet;
    end
  end

  assign faultActive          = state == D_FAULT;
  assign link.driveReadyOut   = driveReady;
  assign link.brakeReleaseOut = brakeRelease;
  // status bit order matches the energise-then-brake sequence
  always_comb
  begin
    link.statusByte = BYTE_RESET;
    link.statusByte[TRAVEL_ACTIVE_STATUS_BIT] = motorEnergise;
    link.statusByte[BRAKE_STATUS_BIT]         = brakeRelease;
  end
endmodule : qshz_drive_end

// ### rtl/qshz_pkg.sv
package qshz_pkg;
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          HOLD_LIMIT_S    = 20;
  localparam int          HOLD_LIMIT_CYC  = HOLD_LIMIT_S * CLK_HZ;
  localparam int          SPEED_LIMIT_MS  = 150;
  localparam int          SPEED_LIMIT_CYC = SPEED_LIMIT_MS * (CLK_HZ / 1000);
  localparam int          CREEP_LIMIT_MM  = 7;
  localparam int          N_INPUTS        = 8;
  localparam int          SEL_W           = 3;
  // command byte one
  localparam int          CMD_ENABLE_BIT  = 0;
  localparam int          TRAVEL_COMMAND_BIT = 1;
  localparam int          OFF_SWITCH_BIT  = 2;
  localparam int          TRAVEL_SPEED_CMD_BIT = 3;
  localparam int          DIRECTION_CMD_BIT = 4;
  // speed byte
  localparam int          ZERO_RPM_CMD_BIT = 2;
  localparam int          INTERMEDIATE_SPEED_CMD_BIT = 6;
  localparam int          FAST_SPEED_CMD_BIT = 7;
  // status byte
  localparam int          TRAVEL_ACTIVE_STATUS_BIT = 1;
  localparam int          BRAKE_STATUS_BIT = 6;
  localparam logic [9:0]  FAULT_NONE      = 10'h000;
  localparam logic [9:0]  FAULT_HOLD_TIME = 10'h30c;
  localparam logic [9:0]  FAULT_HOLD_TRIP = 10'h30d;
  localparam logic [9:0]  FAULT_CREEP     = 10'h211;
  localparam logic [1:0]  SPD_ZERO        = 2'h0;
  localparam logic [1:0]  SPD_POS         = 2'h1;
  localparam logic [1:0]  SPD_INTER       = 2'h2;
  localparam logic [1:0]  SPD_FULL        = 2'h3;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  typedef enum logic [5:0] {
    D_IDLE   = 6'h01,
    D_READY  = 6'h02,
    D_ENERG  = 6'h04,
    D_HOLD   = 6'h08,
    D_TRAVEL = 6'h10,
    D_FAULT  = 6'h20
  } qshz_dev_state_t;
  typedef enum logic [3:0] {
    C_IDLE    = 4'h1,
    C_CLOSING = 4'h2,
    C_RELEASE = 4'h4,
    C_TRAVEL  = 4'h8
  } qshz_ctl_state_t;
endpackage : qshz_pkg

// ### rtl/qshz_link_if.sv
`timescale 1ns/1ps
interface qshz_link_if import qshz_pkg::*; ();
  logic                driveEnableIn;
  logic                travelDirectionIn;
  logic                directionDownIn;
  logic                positioningSpeedIn;
  logic                intermediateSpeedIn;
  logic                fullTravelSpeedIn;
  logic [N_INPUTS-1:0] progIn;
  logic                contactorClosed;
  logic [7:0]          cmdByte;
  logic [7:0]          speedByte;
  logic                driveReadyOut;
  logic                brakeReleaseOut;
  logic [7:0]          statusByte;
  modport drive (
    input  driveEnableIn, travelDirectionIn, directionDownIn,
    input  positioningSpeedIn, intermediateSpeedIn, fullTravelSpeedIn,
    input  progIn, contactorClosed, cmdByte, speedByte,
    output driveReadyOut, brakeReleaseOut, statusByte
  );
  modport ctrl (
    output driveEnableIn, travelDirectionIn, directionDownIn,
    output positioningSpeedIn, intermediateSpeedIn, fullTravelSpeedIn,
    output progIn, contactorClosed, cmdByte, speedByte,
    input  driveReadyOut, brakeReleaseOut, statusByte
  );
endinterface : qshz_link_if

// ### rtl/qshz_ctrl_end.sv
`timescale 1ns/1ps
module qshz_ctrl_end
  import qshz_pkg::*;
#(
  parameter int HOLD_IDX = 0,
  parameter int PF_IDX   = 1
)(
  input  logic       clk,
  input  logic       srst,
  qshz_link_if.ctrl  link,
  input  logic       tripQuick,
  input  logic       tripPlain,
  input  logic       goDown,
  input  logic [1:0] speedReq,
  input  logic       doorClosed,
  input  logic       tripDone,
  input  logic       mainsFail,
  output logic       tripActive
);
  qshz_ctl_state_t     state;
  qshz_ctl_state_t     next_state;
  logic                down;
  logic                next_down;
  logic [1:0]          spd;
  logic [1:0]          next_spd;
  logic                contactor;
  logic                next_contactor;
  logic [N_INPUTS-1:0] progOut;
  logic [N_INPUTS-1:0] next_progOut;

  always_comb
  begin
    next_state = state;
    next_down  = down;
    next_spd   = spd;
    case (state)
      C_IDLE:
      begin
        next_down = goDown;
        next_spd  = (speedReq == SPD_ZERO) ? SPD_POS : speedReq;
        if (tripQuick)
          next_state = C_CLOSING;
        else if (tripPlain)
          next_state = C_TRAVEL;
      end
      C_CLOSING:
        if (doorClosed)
          next_state = C_RELEASE;
      C_RELEASE:
        next_state = C_TRAVEL;
      C_TRAVEL:
        next_state = C_TRAVEL;
      default:
        next_state = C_IDLE;
    endcase
    if (tripDone)
      next_state = C_IDLE;
  end

  always_comb
  begin
    // contactors follow ready one clock later, through the contactor register
    next_contactor = link.driveReadyOut && (next_state != C_IDLE);
    next_progOut = '0;
    next_progOut[HOLD_IDX] = next_state == C_CLOSING;
    next_progOut[PF_IDX]   = mainsFail;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state     <= C_IDLE;
      down      <= 1'b0;
      spd       <= SPD_POS;
      contactor <= 1'b0;
      progOut   <= '0;
    end
    else
    begin
      state     <= next_state;
      down      <= next_down;
      spd       <= next_spd;
      contactor <= next_contactor;
      progOut   <= next_progOut;
    end
  end

  logic enOn;
  logic spdOn;
  assign enOn                     = state != C_IDLE;
  assign spdOn                    = state == C_TRAVEL;
  assign tripActive               = enOn;
  assign link.progIn              = progOut;
  assign link.contactorClosed     = contactor;
  assign link.driveEnableIn       = enOn;
  assign link.travelDirectionIn   = enOn & ~down;
  assign link.directionDownIn     = enOn & down;
  // at most one speed line, only in C_TRAVEL, never together with hold
  assign link.positioningSpeedIn  = spdOn & (spd == SPD_POS);
  assign link.intermediateSpeedIn = spdOn & (spd == SPD_INTER);
  assign link.fullTravelSpeedIn   = spdOn & (spd == SPD_FULL);

  always_comb
  begin
    link.cmdByte   = BYTE_RESET;
    link.speedByte = BYTE_RESET;
    link.cmdByte[CMD_ENABLE_BIT]       = enOn;
    link.cmdByte[TRAVEL_COMMAND_BIT]   = enOn;
    link.cmdByte[OFF_SWITCH_BIT]       = enOn;
    link.cmdByte[TRAVEL_SPEED_CMD_BIT] = enOn;
    link.cmdByte[DIRECTION_CMD_BIT]    = enOn & down;
    link.speedByte[ZERO_RPM_CMD_BIT]   = state == C_CLOSING;
    link.speedByte[INTERMEDIATE_SPEED_CMD_BIT] = spdOn & (spd != SPD_FULL);
    link.speedByte[FAST_SPEED_CMD_BIT] = spdOn & (spd == SPD_FULL);
  end
endmodule : qshz_ctrl_end

// ### testbench/qshz_asserts.sv
`timescale 1ns/1ps
module qshz_asserts
  import qshz_pkg::*;
(
  input logic                clk,
  input logic                srst,
  input logic                driveEnableIn,
  input logic                positioningSpeedIn,
  input logic                intermediateSpeedIn,
  input logic                fullTravelSpeedIn,
  input logic [N_INPUTS-1:0] progIn,
  input logic                contactorClosed,
  input logic                driveReadyOut,
  input logic                brakeReleaseOut,
  input logic [7:0]          statusByte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ready_on_enable: assert property ($rose(driveReadyOut) |-> $past(driveEnableIn))
    else $error("ready rose without enable");
  a_energise_after_close: assert property (
    $rose(statusByte[1]) |-> contactorClosed && driveReadyOut)
    else $error("motor energised without contactor");
  a_brake_after_energ: assert property (
    $rose(brakeReleaseOut) |-> $past(statusByte[1]))
    else $error("brake released before energising");
  a_energ_one_cycle: assert property (
    $rose(statusByte[1]) |=> brakeReleaseOut || !statusByte[1])
    else $error("energise phase longer than one cycle");
  a_brake_status_mirror: assert property (brakeReleaseOut == statusByte[6])
    else $error("brake status bit differs from brake output");
  a_status_spare_zero: assert property (
    statusByte[7] == 1'b0 && statusByte[5:2] == 4'h0 && !statusByte[0])
    else $error("unused status bits set");
  a_brake_needs_ready: assert property (
    brakeReleaseOut |-> driveReadyOut && statusByte[1])
    else $error("brake released without ready and energise");
  a_ready_drops: assert property ($fell(driveEnableIn) |-> ##[1:2] !driveReadyOut)
    else $error("ready kept after enable dropped");
  a_speed_onehot: assert property (
    $onehot0({positioningSpeedIn, intermediateSpeedIn, fullTravelSpeedIn}))
    else $error("more than one speed line");
  a_no_speed_in_hold: assert property (
    progIn[0] |-> !(positioningSpeedIn || intermediateSpeedIn || fullTravelSpeedIn))
    else $error("speed applied while holding zero");
endmodule : qshz_asserts

// ### testbench/quickstart_hold_zero_sequencer_tb.sv
`timescale 1ns/1ps
module quickstart_hold_zero_sequencer_tb
  import qshz_pkg::*;
;
  logic               clk, srst, serialMode, holdFuncEn, pfFuncEn, carHeavyIn, faultReset;
  logic [SEL_W-1:0]   holdSel, pfSel;
  logic signed [31:0] position;
  logic               tripQuick, tripPlain, goDown, doorClosed, tripDone, mainsFail;
  logic [1:0]         speedReq, speedSel;
  logic               motorEnergise, encSupervise, altParamSet, carHeavier, travelDown;
  logic               faultActive, tripActive;
  logic [9:0]         faultCode;
  int                 err_total = 0;
  int                 n_compared = 0;

  qshz_link_if link ();
  qshz_drive_end #(.HOLD_LIMIT(50), .CNT_PER_MM(1)) i_qshz_drive_end (
    .clk(clk), .srst(srst), .link(link), .serialMode(serialMode), .holdFuncEn(holdFuncEn),
    .holdSel(holdSel), .pfFuncEn(pfFuncEn), .pfSel(pfSel), .carHeavyIn(carHeavyIn),
    .faultReset(faultReset), .position(position), .motorEnergise(motorEnergise),
    .encSupervise(encSupervise), .altParamSet(altParamSet), .carHeavier(carHeavier),
    .travelDown(travelDown), .faultActive(faultActive), .faultCode(faultCode),
    .speedSel(speedSel));
  qshz_ctrl_end i_qshz_ctrl_end (
    .clk(clk), .srst(srst), .link(link), .tripQuick(tripQuick), .tripPlain(tripPlain),
    .goDown(goDown), .speedReq(speedReq), .doorClosed(doorClosed), .tripDone(tripDone),
    .mainsFail(mainsFail), .tripActive(tripActive));
  qshz_asserts i_qshz_asserts (
    .clk(clk), .srst(srst), .driveEnableIn(link.driveEnableIn),
    .positioningSpeedIn(link.positioningSpeedIn), .intermediateSpeedIn(link.intermediateSpeedIn),
    .fullTravelSpeedIn(link.fullTravelSpeedIn), .progIn(link.progIn),
    .contactorClosed(link.contactorClosed), .driveReadyOut(link.driveReadyOut),
    .brakeReleaseOut(link.brakeReleaseOut), .statusByte(link.statusByte));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic at(input int n);
    repeat (n) @(posedge clk);
  endtask : at

  // trip ends first so a cleared fault cannot restart a pending request
  task automatic end_trip();
    at(1);
    tripDone <= 1'b1;
    tripQuick <= 1'b0;
    tripPlain <= 1'b0;
    doorClosed <= 1'b0;
    position <= 32'sh0;
    at(3);
    tripDone <= 1'b0;
  endtask : end_trip

  task automatic clear_fault();
    end_trip();
    @(negedge clk);
    chk(faultActive, 1'b1);
    at(1);
    faultReset <= 1'b1;
    at(2);
    faultReset <= 1'b0;
    @(negedge clk);
    chk(faultCode, FAULT_NONE);
  endtask : clear_fault

  task automatic t_quick(input logic ser, input logic [1:0] spd, input logic dn);
    at(1);
    serialMode <= ser;
    speedReq <= spd;
    goDown <= dn;
    carHeavyIn <= dn;
    tripQuick <= 1'b1;
    at(9);
    @(negedge clk);
    chk(link.brakeReleaseOut, 1'b1);
    chk(link.statusByte, 8'h42);
    chk({link.progIn[0], link.speedByte[2]}, 2'h3);
    chk(link.cmdByte[4:0], {dn, 4'hf});
    chk({link.driveReadyOut, motorEnergise, tripActive}, 3'h7);
    chk({link.travelDirectionIn, link.directionDownIn}, {~dn, dn});
    chk(encSupervise, 1'b0);
    at(1);
    doorClosed <= 1'b1;
    at(6);
    @(negedge clk);
    chk(encSupervise, 1'b1);
    chk(speedSel, spd);
    chk(link.speedByte[7:6], {spd == 2'h3, spd != 2'h3});
    chk(link.speedByte[2], 1'b0);
    chk({travelDown, carHeavier}, {dn, dn});
    end_trip();
  endtask : t_quick

  task automatic t_hold_limit();
    at(1);
    tripQuick <= 1'b1;
    at(50);
    @(negedge clk);
    chk(faultActive, 1'b0);
    at(12);
    @(negedge clk);
    chk(faultCode, FAULT_HOLD_TIME);
    chk({link.driveReadyOut, link.brakeReleaseOut}, 2'h0);
    clear_fault();
  endtask : t_hold_limit

  task automatic t_creep();
    at(1);
    tripQuick <= 1'b1;
    at(9);
    position <= 32'sh7;
    at(3);
    @(negedge clk);
    chk(faultActive, 1'b0);
    at(1);
    position <= -32'sh8;
    at(3);
    @(negedge clk);
    chk(faultCode, FAULT_CREEP);
    clear_fault();
  endtask : t_creep

  // hold is made to appear mid-travel by pointing the hold input at the mains-fail line
  task automatic t_misuse();
    at(1);
    holdFuncEn <= 1'b0;
    tripQuick <= 1'b1;
    at(9);
    @(negedge clk);
    chk(link.driveReadyOut, 1'b0);
    at(1);
    holdFuncEn <= 1'b1;
    at(9);
    doorClosed <= 1'b1;
    at(6);
    mainsFail <= 1'b1;
    at(3);
    @(negedge clk);
    chk({altParamSet, faultActive}, 2'h2);
    at(1);
    holdSel <= 3'h1;
    at(3);
    @(negedge clk);
    chk(faultCode, FAULT_HOLD_TRIP);
    at(1);
    holdSel <= 3'h0;
    mainsFail <= 1'b0;
    clear_fault();
    chk(altParamSet, 1'b0);
  endtask : t_misuse

  task automatic t_evac();
    at(1);
    mainsFail <= 1'b1;
    goDown <= 1'b1;
    speedReq <= 2'h1;
    tripPlain <= 1'b1;
    at(10);
    @(negedge clk);
    chk({altParamSet, link.directionDownIn}, 2'h3);
    chk({encSupervise, travelDown, speedSel}, 4'hd);
    end_trip();
    mainsFail <= 1'b0;
  endtask : t_evac

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    srst = 1'b1;
    {serialMode, pfFuncEn, carHeavyIn, faultReset, tripQuick, tripPlain} = 6'h0;
    {goDown, doorClosed, tripDone, mainsFail} = 4'h0;
    holdFuncEn = 1'b1;
    pfFuncEn = 1'b1;
    holdSel = 3'h0;
    pfSel = 3'h1;
    position = 32'sh0;
    speedReq = 2'h1;
    at(6);
    srst <= 1'b0;
    t_quick(1'b0, 2'h2, 1'b0);
    t_quick(1'b1, 2'h3, 1'b1);
    t_quick(1'b0, 2'h1, 1'b1);
    t_hold_limit();
    t_creep();
    t_misuse();
    t_evac();
    final_report();
  end

  // the scenarios need well under a thousand cycles
  initial
  begin
    at(20000);
    err_total++;
    final_report();
  end
endmodule : quickstart_hold_zero_sequencer_tb
